/* File: pdm_pkg.sv */
// Package with constants and carrier types for the power-down mode controller.
package pdm_pkg;

    localparam logic [7:0]  OP_HALT       = 8'h7f;
    localparam logic [7:0]  OP_STOP       = 8'h6f;
    localparam logic [15:0] RESTART_ADDR  = 16'h0020;
    localparam logic [7:0]  TCU_RESET     = 8'hf8;
    localparam int          TCU_WDT_HALT  = 7;
    localparam int          TCU_STOP_DIS  = 3;
    localparam int          WDT_PRESCALE  = 64;
    localparam logic [15:0] WDT_RESET_VAL = 16'hffff;
    localparam int          DIV_BITS      = 3;

    // Oscillator start-up delay after a stop wake, in clock cycles.
    localparam int          OSC_START_CYC = 16;

    // Least low width of the recovery input, in nanoseconds.
    localparam int          MIN_LOW_NS    = 200;
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          MIN_LOW_CYC   =
        (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Power state of the device.
    typedef enum logic [1:0] {
        PDM_RUN,
        PDM_HALT,
        PDM_STOP,
        PDM_WAKE
    } pdm_state_e;

    // Instruction decode strobe from the core.
    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
    } pdm_decode_s;

    // Divided clock enables for the rest of the device.
    typedef struct packed {
        logic div2;
        logic div4;
        logic div8;
    } pdm_clk_en_s;

endpackage

/* File: pdm_ctrl.sv */
// Power-down mode controller: halt, stop, wake sources and clock shaping.
`timescale 1ns/100ps
// Summary of operation
// - Halt stops execution, gates core clock.
// - Timers and interrupts still clocked in halt.
// - Opcode 7F alone enters halt.
// - Interrupt wake resumes after halt opcode.
// - Reset or watchdog in halt restarts 0020H.
// - Stop shuts oscillator and system clock.
// - Opcode 6F alone requests stop.
// - Stop left only by reset or recovery.
// - Stop exit restarts 0020H, sets flag.
// - Flag unchanged by read; software clears.
// - Low wake input triggers recovery in stop.
// - Restart only after wake input high again.
// - Recovery wake keeps control register contents except stop-disable.
// - Oscillator glitch filter; divide-by-2/4/8 enables from clk.
// - Stop-disable bit makes stop a no-op.
// - Every stop wake sets stop-disable again.
// - Watchdog-in-halt bit gates halt resets.
module pdm_ctrl #(
    parameter int WDT_W = 16
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire pdm_pkg::pdm_decode_s decode,
    input  wire logic                irq_pending,
    input  wire logic                irq_enabled,
    input  wire logic                wdt_refresh,
    input  wire logic                tcu_write,
    input  wire logic [7:0]          tcu_wdata,
    input  wire logic                flag_clear,
    input  wire logic                wake_input_pin,
    input  wire logic                osc_input_pin,
    output logic                     osc_output_pin,
    output logic                     core_clk_en,
    output pdm_pkg::pdm_clk_en_s     periph_clk_en,
    output logic                     restart_req,
    output logic [15:0]              restart_addr,
    output logic                     irq_wake,
    output logic                     stop_flag,
    output logic                     wdt_flag,
    output logic [7:0]               timer_control_upper,
    output pdm_pkg::pdm_state_e      state
);

    localparam int DIV_BITS_L = pdm_pkg::DIV_BITS;
    logic [DIV_BITS_L-1:0] div_cnt;
    logic [2:0]            osc_filt;
    logic                  osc_clean;
    logic [5:0]            pre_cnt;
    logic [WDT_W-1:0]      watchdog_counter;
    logic [4:0]            start_cnt;
    logic [7:0]            low_cnt;
    logic                  low_seen;
    logic                  osc_run;
    logic                  halt_dec;
    logic                  stop_dec;
    logic                  wdt_expire;
    logic                  wdt_live;

    assign halt_dec = decode.valid && decode.opcode == pdm_pkg::OP_HALT
                      && state == pdm_pkg::PDM_RUN;
    assign stop_dec = decode.valid && decode.opcode == pdm_pkg::OP_STOP
                      && state == pdm_pkg::PDM_RUN;
    assign osc_run  = state != pdm_pkg::PDM_STOP;
    assign wdt_live = state == pdm_pkg::PDM_RUN ||
        (state == pdm_pkg::PDM_HALT &&
         timer_control_upper[pdm_pkg::TCU_WDT_HALT]);
    assign wdt_expire = wdt_live && periph_clk_en.div8 &&
        pre_cnt == 6'(pdm_pkg::WDT_PRESCALE - 1) &&
        watchdog_counter == '0;

    //--------------------------------------------------------------
    // Oscillator and clock shaping
    //--------------------------------------------------------------

    // The oscillator drives out only while not stopped; a majority
    // vote over three samples rejects single-cycle glitches.
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_output_pin <= 1'b0;
            osc_filt       <= 3'h0;
        end else begin
            osc_output_pin <= osc_run ? ~osc_input_pin : 1'b0;
            osc_filt       <= {osc_filt[1:0], osc_output_pin};
        end
    end

    assign osc_clean = (osc_filt[0] & osc_filt[1]) |
                       (osc_filt[1] & osc_filt[2]) |
                       (osc_filt[0] & osc_filt[2]);

    // Divider counts clk cycles; the oscillator's own edges are kept
    // only as a filtered observation because the design has one clock.
    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt       <= '0;
            periph_clk_en <= '0;
        end else if (!osc_run) begin
            periph_clk_en <= '0;
        end else begin
            div_cnt            <= div_cnt + 1'b1;
            periph_clk_en.div2 <= div_cnt[0];
            periph_clk_en.div4 <= div_cnt[1:0] == 2'h3;
            periph_clk_en.div8 <= div_cnt == 3'h7;
        end
    end

    // Core clock enable runs only in the run state.
    always_ff @(posedge clk) begin
        if (reset) begin
            core_clk_en <= 1'b0;
        end else begin
            core_clk_en <= state == pdm_pkg::PDM_RUN && !halt_dec
                           && !(stop_dec && !timer_control_upper
                                [pdm_pkg::TCU_STOP_DIS]);
        end
    end

    //--------------------------------------------------------------
    // Watchdog counter
    //--------------------------------------------------------------

    // Ticks once every 64 divide-by-8 enables; frozen in stop.
    always_ff @(posedge clk) begin
        if (reset || wdt_refresh || wdt_expire) begin
            pre_cnt          <= '0;
            watchdog_counter <= WDT_W'(pdm_pkg::WDT_RESET_VAL);
        end else if (wdt_live && periph_clk_en.div8) begin
            pre_cnt <= pre_cnt + 1'b1;
            if (pre_cnt == 6'(pdm_pkg::WDT_PRESCALE - 1)) begin
                watchdog_counter <= watchdog_counter - 1'b1;
            end
        end
    end

    //--------------------------------------------------------------
    // Power state machine
    //--------------------------------------------------------------

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= pdm_pkg::PDM_RUN;
        end else begin
            case (state)
                pdm_pkg::PDM_RUN: begin
                    if (halt_dec) begin
                        state <= pdm_pkg::PDM_HALT;
                    end else if (stop_dec && !timer_control_upper
                                 [pdm_pkg::TCU_STOP_DIS]) begin
                        state <= pdm_pkg::PDM_STOP;
                    end
                end
                pdm_pkg::PDM_HALT: begin
                    if (wdt_expire || (irq_pending && irq_enabled)) begin
                        state <= pdm_pkg::PDM_RUN;
                    end
                end
                pdm_pkg::PDM_STOP: begin
                    if (low_seen && wake_input_pin) begin
                        state <= pdm_pkg::PDM_WAKE;
                    end
                end
                default: begin
                    if (start_cnt == 5'(pdm_pkg::OSC_START_CYC - 1)) begin
                        state <= pdm_pkg::PDM_RUN;
                    end
                end
            endcase
        end
    end

    // Recovery low width and oscillator start-up counters.
    always_ff @(posedge clk) begin
        if (reset || state != pdm_pkg::PDM_STOP) begin
            low_cnt  <= '0;
            low_seen <= 1'b0;
        end else if (!wake_input_pin) begin
            if (low_cnt != 8'(pdm_pkg::MIN_LOW_CYC)) begin
                low_cnt <= low_cnt + 1'b1;
            end
            low_seen <= low_cnt >= 8'(pdm_pkg::MIN_LOW_CYC - 1);
        end else if (!low_seen) begin
            low_cnt <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || state != pdm_pkg::PDM_WAKE) begin
            start_cnt <= '0;
        end else begin
            start_cnt <= start_cnt + 1'b1;
        end
    end

    //--------------------------------------------------------------
    // Restart, wake and flags
    //--------------------------------------------------------------

    // Restart at the fixed address after watchdog or stop wake.
    always_ff @(posedge clk) begin
        if (reset) begin
            restart_req  <= 1'b1;
            restart_addr <= pdm_pkg::RESTART_ADDR;
            irq_wake     <= 1'b0;
        end else begin
            restart_req  <= wdt_expire || (state == pdm_pkg::PDM_WAKE &&
                start_cnt == 5'(pdm_pkg::OSC_START_CYC - 1));
            restart_addr <= pdm_pkg::RESTART_ADDR;
            irq_wake     <= state == pdm_pkg::PDM_HALT && !wdt_expire
                            && irq_pending && irq_enabled;
        end
    end

    // Sticky flags: hardware set wins over a software clear. Reads
    // have no side effect since the flag is just a level.
    always_ff @(posedge clk) begin
        if (reset) begin
            stop_flag <= 1'b0;
            wdt_flag  <= 1'b0;
        end else begin
            if (state == pdm_pkg::PDM_WAKE) begin
                stop_flag <= 1'b1;
            end else if (flag_clear) begin
                stop_flag <= 1'b0;
            end
            if (wdt_expire) begin
                wdt_flag <= 1'b1;
            end else if (flag_clear) begin
                wdt_flag <= 1'b0;
            end
        end
    end

    // Control register is only reset by the pin, never by a recovery
    // wake; the wake does force stop-disable back on.
    always_ff @(posedge clk) begin
        if (reset) begin
            timer_control_upper <= pdm_pkg::TCU_RESET;
        end else if (state == pdm_pkg::PDM_WAKE) begin
            timer_control_upper[pdm_pkg::TCU_STOP_DIS] <= 1'b1;
        end else if (tcu_write) begin
            timer_control_upper <= {tcu_wdata[7:3], 3'h0};
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------

    property p_halt_entry;
        @(posedge clk) disable iff (reset)
        halt_dec |=> state == pdm_pkg::PDM_HALT ##1 !core_clk_en;
    endproperty
    a_halt_entry: assert property (p_halt_entry)
        else $error("Halt opcode did not halt the core.");

    property p_stop_nop;
        @(posedge clk) disable iff (reset)
        stop_dec && timer_control_upper[pdm_pkg::TCU_STOP_DIS]
            |=> state == pdm_pkg::PDM_RUN;
    endproperty
    a_stop_nop: assert property (p_stop_nop)
        else $error("Stop taken while disabled.");

    property p_stop_entry;
        @(posedge clk) disable iff (reset)
        stop_dec && !timer_control_upper[pdm_pkg::TCU_STOP_DIS]
            |=> state == pdm_pkg::PDM_STOP;
    endproperty
    a_stop_entry: assert property (p_stop_entry)
        else $error("Stop opcode did not enter stop.");

    property p_stop_frozen;
        @(posedge clk) disable iff (reset)
        state == pdm_pkg::PDM_STOP ##1 state == pdm_pkg::PDM_STOP
            |-> periph_clk_en == '0 && $stable(watchdog_counter);
    endproperty
    a_stop_frozen: assert property (p_stop_frozen)
        else $error("Clocks ran during stop.");

    property p_stop_exit;
        @(posedge clk) disable iff (reset)
        state == pdm_pkg::PDM_STOP && !low_seen
            |=> state == pdm_pkg::PDM_STOP;
    endproperty
    a_stop_exit: assert property (p_stop_exit)
        else $error("Stop left without recovery.");

    property p_wake_flags;
        @(posedge clk) disable iff (reset)
        state == pdm_pkg::PDM_WAKE |=> stop_flag &&
            timer_control_upper[pdm_pkg::TCU_STOP_DIS];
    endproperty
    a_wake_flags: assert property (p_wake_flags)
        else $error("Wake did not set flag and stop-disable.");

    property p_wake_restart;
        @(posedge clk) disable iff (reset)
        $rose(state == pdm_pkg::PDM_WAKE) |-> ##16 restart_req &&
            restart_addr == pdm_pkg::RESTART_ADDR;
    endproperty
    a_wake_restart: assert property (p_wake_restart)
        else $error("No restart after stop wake.");

    property p_halt_irq;
        @(posedge clk) disable iff (reset)
        state == pdm_pkg::PDM_HALT && !(irq_pending && irq_enabled)
            && !wdt_expire |=> state == pdm_pkg::PDM_HALT;
    endproperty
    a_halt_irq: assert property (p_halt_irq)
        else $error("Halt left without enabled interrupt.");

    property p_flag_hold;
        @(posedge clk) disable iff (reset)
        stop_flag && !flag_clear |=> stop_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("Stop flag lost without clear.");

    c_halt_irq: cover property (@(posedge clk) disable iff (reset)
        state == pdm_pkg::PDM_HALT ##1 irq_wake);
    c_stop_wake: cover property (@(posedge clk) disable iff (reset)
        state == pdm_pkg::PDM_STOP ##1 state == pdm_pkg::PDM_WAKE);
    c_wdt_halt: cover property (@(posedge clk) disable iff (reset)
        state == pdm_pkg::PDM_HALT && wdt_expire);
    c_osc_filtered: cover property (@(posedge clk) disable iff (reset)
        osc_clean ##1 !osc_clean);

endmodule

/* File: pdm_core_model.sv */
// Behavioural model of the core decode strobe and the external wake line.
`timescale 1ns/100ps
module pdm_core_model (
    input  wire logic            clk,
    output pdm_pkg::pdm_decode_s decode,
    output logic                 wake_input_pin
);
    // ---------------------------------------------------------------
    // Idle levels
    // ---------------------------------------------------------------
    // The wake line is an input with a pull-up, so it idles high.
    initial begin
        decode         = '0;
        wake_input_pin = 1'b1;
    end

    // ---------------------------------------------------------------
    // Requests
    // ---------------------------------------------------------------
    // One opcode for one cycle; the idle bus then carries the inverse,
    // so a stale opcode can never be mistaken for a fresh one.
    task automatic issue(input logic [7:0] op);
        @(posedge clk);
        decode.valid  <= 1'b1;
        decode.opcode <= op;
        @(posedge clk);
        decode.valid  <= 1'b0;
        decode.opcode <= ~op;
    endtask

    // Hold the wake line low for a number of cycles, then release it.
    task automatic wake_low(input int cycles);
        @(posedge clk);
        wake_input_pin <= 1'b0;
        repeat (cycles) @(posedge clk);
        wake_input_pin <= 1'b1;
    endtask
endmodule

/* File: power_down_mode_control_tb_top.sv */
// Self-checking testbench for the power-down mode controller.
`timescale 1ns/100ps
module power_down_mode_control_tb_top;
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    pdm_pkg::pdm_decode_s decode;
    logic                 irq_pending = 1'b0;
    logic                 irq_enabled = 1'b0;
    logic                 wdt_refresh = 1'b0;
    logic                 tcu_write = 1'b0;
    logic [7:0]           tcu_wdata = 8'h00;
    logic                 flag_clear = 1'b0;
    logic                 wake_input_pin;
    logic                 osc_input_pin = 1'b0;
    logic                 osc_output_pin;
    logic                 core_clk_en;
    pdm_pkg::pdm_clk_en_s periph_clk_en;
    logic                 restart_req;
    logic [15:0]          restart_addr;
    logic                 irq_wake;
    logic                 stop_flag;
    logic                 wdt_flag;
    logic [7:0]           timer_control_upper;
    pdm_pkg::pdm_state_e  state;
    logic                 refresh_on = 1'b1;
    logic [5:0]           refresh_cnt = 6'h00;
    int                   errors = 0;
    int                   comparisons = 0;
    int                   n;
    int                   n2;
    int                   n4;
    int                   n8;

    // ---------------------------------------------------------------
    // Design and partner
    // ---------------------------------------------------------------
    // A narrow watchdog keeps its expiry within a few thousand cycles.
    pdm_ctrl #(.WDT_W(4)) dut (
        .clk(clk), .reset(reset), .decode(decode),
        .irq_pending(irq_pending), .irq_enabled(irq_enabled),
        .wdt_refresh(wdt_refresh), .tcu_write(tcu_write),
        .tcu_wdata(tcu_wdata), .flag_clear(flag_clear),
        .wake_input_pin(wake_input_pin), .osc_input_pin(osc_input_pin),
        .osc_output_pin(osc_output_pin), .core_clk_en(core_clk_en),
        .periph_clk_en(periph_clk_en), .restart_req(restart_req),
        .restart_addr(restart_addr), .irq_wake(irq_wake),
        .stop_flag(stop_flag), .wdt_flag(wdt_flag),
        .timer_control_upper(timer_control_upper), .state(state)
    );
    pdm_core_model core (
        .clk(clk), .decode(decode), .wake_input_pin(wake_input_pin)
    );

    // Clock, oscillator stand-in and periodic watchdog service.
    always #20 clk = ~clk;
    always @(posedge clk) begin
        osc_input_pin <= ~osc_input_pin;
        refresh_cnt   <= refresh_cnt + 6'h01;
        wdt_refresh   <= refresh_on && (refresh_cnt == 6'h00);
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Compare one value; unknowns never count as a match.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t mismatch: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask
    // Let clock edges pass and settle just after the last one.
    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Pulse a write of the upper timer control byte.
    task automatic write_tcu(input logic [7:0] v);
        @(posedge clk);
        tcu_write <= 1'b1;
        tcu_wdata <= v;
        @(posedge clk);
        tcu_write <= 1'b0;
        #1;
    endtask
    // Pulse the flag clear strobe.
    task automatic clear_flags;
        @(posedge clk);
        flag_clear <= 1'b1;
        @(posedge clk);
        flag_clear <= 1'b0;
        #1;
    endtask
    // Raise an enabled interrupt for one cycle.
    task automatic raise_irq;
        @(posedge clk);
        irq_pending <= 1'b1;
        irq_enabled <= 1'b1;
        @(posedge clk);
        irq_pending <= 1'b0;
        irq_enabled <= 1'b0;
        #1;
    endtask
    // Wait, bounded, for a restart request.
    task automatic wait_restart(input int lim);
        n = 0;
        while (restart_req !== 1'b1 && n < lim) begin
            cycles(1);
            n++;
        end
    endtask
    // Print the verdict and end the run.
    task automatic test_done;
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Values after reset and divided enable rates while running.
    task automatic t_reset_and_clock;
        check(16'(timer_control_upper), 16'h00f8);
        check(16'(stop_flag), 16'h0000);
        check(restart_addr, 16'h0020);
        check(16'(core_clk_en), 16'h0001);
        {n2, n4, n8} = '0;
        repeat (64) begin
            cycles(1);
            n2 += int'(periph_clk_en.div2);
            n4 += int'(periph_clk_en.div4);
            n8 += int'(periph_clk_en.div8);
        end
        check(16'(n2), 16'd32);
        check(16'(n4), 16'd16);
        check(16'(n8), 16'd8);
    endtask
    // Halt: a disabled request must not wake, an enabled one must.
    task automatic t_halt;
        core.issue(pdm_pkg::OP_HALT);
        #1;
        check(16'(state), 16'(pdm_pkg::PDM_HALT));
        check(16'(core_clk_en), 16'h0000);
        @(posedge clk);
        irq_pending <= 1'b1;
        n8 = 0;
        n = 0;
        repeat (16) begin
            cycles(1);
            n8 += int'(periph_clk_en.div8);
            n += int'(osc_output_pin);
        end
        check(16'(n8), 16'd2);
        check(16'(n), 16'd8);
        check(16'(state), 16'(pdm_pkg::PDM_HALT));
        raise_irq();
        check(16'(state), 16'(pdm_pkg::PDM_RUN));
        check(16'(irq_wake), 16'h0001);
        cycles(1);
        check(16'(core_clk_en), 16'h0001);
    endtask
    // Stop refused, then stop entered and left through the wake line.
    task automatic t_stop;
        core.issue(pdm_pkg::OP_STOP);
        cycles(3);
        check(16'(state), 16'(pdm_pkg::PDM_RUN));
        write_tcu(8'h77);
        check(16'(timer_control_upper), 16'h0070);
        refresh_on = 1'b0;
        core.issue(pdm_pkg::OP_STOP);
        #1;
        check(16'(state), 16'(pdm_pkg::PDM_STOP));
        @(posedge clk);
        irq_pending <= 1'b1;
        irq_enabled <= 1'b1;
        n = 0;
        repeat (8) begin
            cycles(1);
            n += int'(|periph_clk_en) + int'(osc_output_pin);
        end
        check(16'(n), 16'h0000);
        check(16'(state), 16'(pdm_pkg::PDM_STOP));
        @(posedge clk);
        irq_pending <= 1'b0;
        irq_enabled <= 1'b0;
        core.wake_low(6);
        #1;
        check(16'(state), 16'(pdm_pkg::PDM_STOP));
        cycles(1);
        check(16'(state), 16'(pdm_pkg::PDM_WAKE));
        wait_restart(40);
        check(16'(n), 16'd16);
        check(restart_addr, 16'h0020);
        check(16'(stop_flag), 16'h0001);
        check(16'(timer_control_upper), 16'h0078);
        cycles(5);
        check(16'(stop_flag), 16'h0001);
        clear_flags();
        check(16'(stop_flag), 16'h0000);
        refresh_on = 1'b1;
        core.issue(pdm_pkg::OP_STOP);
        cycles(3);
        check(16'(state), 16'(pdm_pkg::PDM_RUN));
    endtask
    // Reset pin ends halt, then watchdog blocked and active in halt.
    task automatic t_halt_resets;
        core.issue(pdm_pkg::OP_HALT);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1;
        check(16'(state), 16'(pdm_pkg::PDM_RUN));
        check(16'(restart_req), 16'h0001);
        write_tcu(8'h78);
        refresh_on = 1'b0;
        core.issue(pdm_pkg::OP_HALT);
        cycles(10000);
        check(16'(state), 16'(pdm_pkg::PDM_HALT));
        check(16'(wdt_flag), 16'h0000);
        raise_irq();
        refresh_on = 1'b1;
        write_tcu(8'hf8);
        cycles(70);
        refresh_on = 1'b0;
        core.issue(pdm_pkg::OP_HALT);
        wait_restart(15000);
        check(16'(restart_req), 16'h0001);
        check(16'(wdt_flag), 16'h0001);
        check(restart_addr, 16'h0020);
        refresh_on = 1'b1;
        clear_flags();
        check(16'(wdt_flag), 16'h0000);
    endtask

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    // Reset for 20 cycles, then run every scenario in turn.
    initial begin
        cycles(19);
        check(16'(restart_req), 16'h0001);
        @(posedge clk);
        reset <= 1'b0;
        cycles(2);
        t_reset_and_clock();
        t_halt();
        t_stop();
        t_halt_resets();
        test_done();
    end
    // A hang is cut short well beyond the expected run length.
    initial begin
        #(40 * 60000);
        errors++;
        test_done();
    end
endmodule
